// File: verilog/program_sequencer_config.sv
`timescale 1ns/1ps
module program_sequencer_config
  import seq_pkg::*;
  #(parameter logic [11:0] PART_ID = PART_ID_DEFAULT)
  (input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [11:0] extended_config_word_i,
   input wire seq_op_t op_i,
   input wire logic [4:0] data_addr_i,
   input wire logic data_we_i,
   input wire logic data_rd_i,
   input wire logic [7:0] data_wdata_i,
   input wire logic option_we_i,
   input wire logic [7:0] option_wdata_i,
   input wire logic carry_flag_i,
   input wire logic prog_we_i,
   input wire logic [10:0] prog_addr_i,
   input wire logic [11:0] prog_wdata_i,
   output logic [7:0] data_rdata_o,
   output logic [10:0] pc_o,
   output logic [11:0] insn_o,
   output logic [7:0] option_o,
   output logic add_carry_in_o,
   output cfg_t cfg_o,
   output logic [4:0] rc_freq_step_o,
   output logic [2:0] page_count_o,
   output logic [3:0] bank_count_o,
   output logic [11:0] part_identification_word_o);

  // -------------------------------------------------------
  // primary_config_word capture
  // -------------------------------------------------------
  logic [11:0] primary_config_word_meta_reg;
  logic [11:0] primary_config_word_sync_reg;
  logic [11:0] extended_config_word_reg;

  // the primary_config_word pins come from outside the clock domain
  always_ff @(posedge sys_clk_i)
  begin
    primary_config_word_meta_reg <= extended_config_word_i;
    primary_config_word_sync_reg <= primary_config_word_meta_reg;
  end

  // sampled only while reset is high, so a primary_config_word that is
  // reprogrammed later has no effect until the next reset
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      extended_config_word_reg <= primary_config_word_sync_reg;
  end

  // -------------------------------------------------------
  // configuration decode
  // -------------------------------------------------------
  logic [10:0] pc_max;
  logic [2:0] bank_mask;

  // field decode of the held word
  always_comb
  begin
    cfg_o.rc_trim = {extended_config_word_reg[FX_TRIM2],
                     extended_config_word_reg[FX_TRIM1],
                     extended_config_word_reg[FX_TRIM0]};
    cfg_o.pin_select = extended_config_word_reg[FX_PINS];
    cfg_o.option_stack_extend = extended_config_word_reg[FX_OPTX];
    cfg_o.carry_in_en = !extended_config_word_reg[FX_CARRY_N];
    cfg_o.brownout_select = {extended_config_word_reg[FX_BOR1],
                             extended_config_word_reg[FX_BOR0]};
    cfg_o.brownout_en = (cfg_o.brownout_select != BOR_OFF);
    cfg_o.brownout_trim = {extended_config_word_reg[FX_BTRIM1],
                           extended_config_word_reg[FX_BTRIM2]};
    cfg_o.memory_size_select = {extended_config_word_reg[FX_BP1],
                                extended_config_word_reg[FX_BP0]};
  end

  // trim code as percent above the slowest setting; the
  // analog oscillator takes the code itself
  assign rc_freq_step_o = 5'(cfg_o.rc_trim * TRIM_STEP_PCT);

  // memory size selects pages, banks and the top address
  always_comb
  begin
    case (cfg_o.memory_size_select)
      2'h0:
      begin
        page_count_o = 3'h1;
        bank_count_o = 4'h1;
        bank_mask = 3'h0;
        pc_max = PC_MAX_ONE_PAGE;
      end
      2'h1:
      begin
        page_count_o = 3'h1;
        bank_count_o = 4'h2;
        bank_mask = 3'h1;
        pc_max = PC_MAX_ONE_PAGE;
      end
      2'h2:
      begin
        page_count_o = 3'h4;
        bank_count_o = 4'h4;
        bank_mask = 3'h3;
        pc_max = PC_RESET;
      end
      default:
      begin
        page_count_o = 3'h4;
        bank_count_o = 4'h8;
        bank_mask = 3'h7;
        pc_max = PC_RESET;
      end
    endcase
  end

  // carry joins add and subtract only when the primary_config_word asks
  assign add_carry_in_o = cfg_o.carry_in_en & carry_flag_i;

  // hard wired, no write path exists
  assign part_identification_word_o = PART_ID;

  // -------------------------------------------------------
  // option register
  // -------------------------------------------------------
  logic [7:0] option_reg;

  // all ones after reset; top two bits software-owned
  // only without the extension
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      option_reg <= OPTION_RESET;
    else if (option_we_i)
      option_reg <= option_wdata_i;
  end

  assign option_o = cfg_o.option_stack_extend ?
                    {2'h3, option_reg[5:0]} : option_reg;

  // -------------------------------------------------------
  // program counter and page bits
  // -------------------------------------------------------
  logic [2:0] page_reg;
  logic [10:0] pc_reg;
  logic [10:0] pc_inc;
  logic [10:0] stack_top;
  logic data_wr_pc;
  logic data_wr_status;
  logic data_wr_fsr;
  logic [4:0] eff_addr;
  logic [7:0] fsr_reg;

  // page bits are ignored by the increment, so the count
  // runs across 512-word pages and wraps at the top
  assign pc_inc = (pc_reg >= pc_max) ? 11'h000 :
                  11'(pc_reg + 11'h001);

  // indirect access goes through the pointer's low bits
  assign eff_addr = (data_addr_i == ADDR_INDIRECT) ?
                    fsr_reg[4:0] : data_addr_i;
  assign data_wr_pc = data_we_i && (eff_addr == ADDR_PC_LOW);
  assign data_wr_status = data_we_i && (eff_addr == ADDR_STATUS);
  assign data_wr_fsr = data_we_i && (eff_addr == ADDR_FSR);

  // page instruction wins over a status write in one cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      page_reg <= PAGE_RESET;
    else if (op_i.page_load)
      page_reg <= op_i.page_val;
    else if (data_wr_status)
      page_reg <= data_wdata_i[STATUS_PAGE_LSB +: 3];
  end

  // return beats call beats jump beats a write beats a step;
  // the decoder issues one of them per instruction
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      pc_reg <= pc_max;
    else if (op_i.ret)
      pc_reg <= stack_top;
    else if (op_i.call || op_i.jump)
      pc_reg <= {page_reg, op_i.target};
    else if (data_wr_pc)
      pc_reg <= {page_reg, data_wdata_i};
    else if (op_i.step)
      pc_reg <= pc_inc;
  end

  assign pc_o = pc_reg;

  // -------------------------------------------------------
  // return stack
  // -------------------------------------------------------
  // only call and return touch it; no data address
  // reaches it
  call_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack
    (.sys_clk_i(sys_clk_i),
     .rst_i(rst_i),
     .push_i(op_i.call && !op_i.ret),
     .pop_i(op_i.ret),
     .short_i(cfg_o.option_stack_extend),
     .push_data_i(pc_inc),
     .top_o(stack_top));

  // -------------------------------------------------------
  // program store
  // -------------------------------------------------------
  // fetch of the word at the counter, one cycle later
  sync_ram #(.WIDTH(INSN_W), .DEPTH(PROG_DEPTH), .AW(PC_W)) u_prog
    (.sys_clk_i(sys_clk_i),
     .we_i(prog_we_i),
     .waddr_i(prog_addr_i),
     .wdata_i(prog_wdata_i),
     .raddr_i(pc_reg),
     .rdata_o(insn_o));

  // -------------------------------------------------------
  // data memory
  // -------------------------------------------------------
  logic [DATA_AW-1:0] ram_idx;
  logic is_fn;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic fn_sel_reg;
  logic [7:0] fn_data_reg;
  logic [7:0] fn_data;

  // bank select is cut to the banks the size field allows
  // low half below 08h is function registers
  always_comb
  begin
    is_fn = (eff_addr < ADDR_RAM_LO);
    if (!eff_addr[4])
      ram_idx = DATA_AW'(eff_addr[3:0] - 4'h8);
    else
      ram_idx = RAM_BANKED_BASE +
                {1'b0, fsr_reg[FSR_BANK_LSB +: 3] & bank_mask,
                 eff_addr[3:0]};
  end

  assign ram_we = data_we_i && !is_fn;

  // pointer register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      fsr_reg <= FSR_RESET;
    else if (data_wr_fsr)
      fsr_reg <= data_wdata_i;
  end

  // function register readback; unused ones read zero
  always_comb
  begin
    case (eff_addr)
      ADDR_PC_LOW: fn_data = pc_reg[7:0];
      ADDR_STATUS: fn_data = {page_reg, 5'h00};
      ADDR_FSR: fn_data = fsr_reg;
      default: fn_data = 8'h00;
    endcase
  end

  // read source follows the RAM latency of one cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fn_sel_reg <= 1'b1;
      fn_data_reg <= 8'h00;
    end
    else if (data_rd_i)
    begin
      fn_sel_reg <= is_fn;
      fn_data_reg <= fn_data;
    end
  end

  sync_ram #(.WIDTH(8), .DEPTH(DATA_DEPTH), .AW(DATA_AW)) u_data
    (.sys_clk_i(sys_clk_i),
     .we_i(ram_we),
     .waddr_i(ram_idx),
     .wdata_i(data_wdata_i),
     .raddr_i(ram_idx),
     .rdata_o(ram_rdata));

  assign data_rdata_o = fn_sel_reg ? fn_data_reg : ram_rdata;

  // -------------------------------------------------------
  // checks
  // -------------------------------------------------------
  a_reset_vector: assert property (@(posedge sys_clk_i)
    $fell(rst_i) |-> pc_reg == pc_max)
    else $error("counter not at top address after reset");

  a_pc_step: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    op_i.step && !op_i.ret && !op_i.call && !op_i.jump &&
    !data_wr_pc |=> pc_reg == (($past(pc_reg) >= pc_max) ?
    11'h000 : 11'($past(pc_reg) + 11'h001)))
    else $error("sequential step wrong");

  a_jump_target: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    op_i.jump && !op_i.ret |=>
    pc_reg == {$past(page_reg), $past(op_i.target)})
    else $error("branch target wrong");

  a_call_push: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    op_i.call && !op_i.ret |=> stack_top == $past(pc_inc))
    else $error("return address not pushed");

  a_ret_restore: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    op_i.call && !op_i.ret ##1 op_i.ret |=>
    pc_reg == $past(pc_inc, 2))
    else $error("return does not restore counter");

  a_page_load: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    op_i.page_load |=> page_reg == $past(op_i.page_val))
    else $error("page bits not loaded");

  a_option_force: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    cfg_o.option_stack_extend |-> option_o[7:6] == 2'h3)
    else $error("option bits not forced");

  a_option_free: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    option_we_i && !cfg_o.option_stack_extend |=>
    option_o == $past(option_wdata_i))
    else $error("option write lost");

  a_bor_decode: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    cfg_o.brownout_en != (&extended_config_word_reg[FX_BOR1:FX_BOR0]))
    else $error("brown-out decode wrong");

  a_cfg_hold: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    !$past(rst_i) |-> $stable(extended_config_word_reg))
    else $error("primary_config_word word changed outside reset");

  a_id_fixed: assert property (@(posedge sys_clk_i)
    part_identification_word_o == PART_ID)
    else $error("part code changed");
endmodule

// File: verilog/seq_pkg.sv
package seq_pkg;
  // -------------------------------------------------------
  // widths and depths
  // -------------------------------------------------------
  localparam int PC_W = 11;
  localparam int INSN_W = 12;
  localparam int PROG_DEPTH = 2048;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_SHORT = 2;
  localparam int DATA_DEPTH = 136;
  localparam int DATA_AW = 8;

  // -------------------------------------------------------
  // reset values and fixed words
  // -------------------------------------------------------
  localparam logic [10:0] PC_RESET = 11'h7FF;
  localparam logic [10:0] PC_MAX_ONE_PAGE = 11'h1FF;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] FSR_RESET = 8'h00;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  // part code: arbitrary value
  localparam logic [11:0] PART_ID_DEFAULT = 12'h5A3;

  // -------------------------------------------------------
  // data addresses of the function registers
  // -------------------------------------------------------
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_PC_LOW = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_FSR = 5'h04;
  localparam logic [4:0] ADDR_RAM_LO = 5'h08;
  localparam int STATUS_PAGE_LSB = 5;
  localparam int FSR_BANK_LSB = 5;
  localparam logic [7:0] RAM_BANKED_BASE = 8'h08;

  // -------------------------------------------------------
  // extended configuration word field positions
  // -------------------------------------------------------
  localparam int FX_TRIM2 = 11;
  localparam int FX_PINS = 10;
  localparam int FX_TRIM1 = 9;
  localparam int FX_TRIM0 = 8;
  localparam int FX_OPTX = 7;
  localparam int FX_CARRY_N = 6;
  localparam int FX_BOR1 = 5;
  localparam int FX_BOR0 = 4;
  localparam int FX_BTRIM1 = 3;
  localparam int FX_BTRIM2 = 2;
  localparam int FX_BP1 = 1;
  localparam int FX_BP0 = 0;
  localparam logic [1:0] BOR_OFF = 2'h3;
  localparam logic [4:0] TRIM_STEP_PCT = 5'h3;

  // decoded configuration, held from reset to reset
  typedef struct packed {
    logic [2:0] rc_trim;
    logic pin_select;
    logic option_stack_extend;
    logic carry_in_en;
    logic [1:0] brownout_select;
    logic brownout_en;
    logic [1:0] brownout_trim;
    logic [1:0] memory_size_select;
  } cfg_t;

  // sequencing request from the instruction decoder
  typedef struct packed {
    logic step;
    logic jump;
    logic call;
    logic ret;
    logic page_load;
    logic [2:0] page_val;
    logic [7:0] target;
  } seq_op_t;
endpackage

// File: verilog/sync_ram.sv
`timescale 1ns/1ps
// one write port, one read port with registered read data
module sync_ram
  #(parameter int WIDTH = 12,
    parameter int DEPTH = 2048,
    parameter int AW = 11)
  (input wire logic sys_clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o);

  logic [WIDTH-1:0] mem [DEPTH];

  // write; out of range addresses are dropped
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i && (int'(waddr_i) < DEPTH))
      mem[waddr_i] <= wdata_i;
  end

  // read data registered, old data on a same-address write
  always_ff @(posedge sys_clk_i)
  begin
    rdata_o <= mem[raddr_i];
  end
endmodule

// File: verilog/call_stack.sv
`timescale 1ns/1ps
// shift-register return stack, not reachable from data space
module call_stack
  #(parameter int DEPTH = 8,
    parameter int WIDTH = 11)
  (input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic short_i,
   input wire logic [WIDTH-1:0] push_data_i,
   output logic [WIDTH-1:0] top_o);

  import seq_pkg::*;

  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [31:0] limit;

  assign limit = short_i ? STACK_SHORT : DEPTH;
  assign top_o = entry_reg[0];

  // each entry moves one place per push or pop
  // a push on a full stack drops the oldest
  // entries beyond the limit freeze in the short mode
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
        entry_reg[i] <= '0;
      else if (push_i && (i < limit))
        entry_reg[i] <= (i == 0) ? push_data_i : entry_reg[(i+DEPTH-1)%DEPTH];
      else if (pop_i && (i + 1 < limit))
        entry_reg[i] <= entry_reg[i+1];
    end
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import seq_pkg::*;
;
  // -------------------------------------------------------
  // stimulus and observed signals
  // -------------------------------------------------------
  localparam logic [4:0] K_STEP = 5'h10;
  localparam logic [4:0] K_JUMP = 5'h08;
  localparam logic [4:0] K_CALL = 5'h04;
  localparam logic [4:0] K_RET = 5'h02;
  localparam logic [4:0] K_PAGE = 5'h01;
  logic sys_clk_i;
  logic rst_i;
  logic [11:0] primary_config_word;
  seq_op_t op_i;
  logic [4:0] data_addr_i;
  logic data_we_i;
  logic data_rd_i;
  logic [7:0] data_wdata_i;
  logic option_we_i;
  logic [7:0] option_wdata_i;
  logic carry_flag_i;
  logic prog_we_i;
  logic [10:0] prog_addr_i;
  logic [11:0] prog_wdata_i;
  logic [7:0] data_rdata_o;
  logic [10:0] pc_o;
  logic [11:0] insn_o;
  logic [7:0] option_o;
  logic add_carry_in_o;
  cfg_t cfg;
  logic [4:0] rc_freq_step_o;
  logic [2:0] page_count_o;
  logic [3:0] bank_count_o;
  logic [11:0] part_word;
  int bad_count;
  int compares;
  logic [10:0] e;

  program_sequencer_config dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .extended_config_word_i(primary_config_word), .op_i(op_i),
    .data_addr_i(data_addr_i), .data_we_i(data_we_i),
    .data_rd_i(data_rd_i), .data_wdata_i(data_wdata_i),
    .option_we_i(option_we_i), .option_wdata_i(option_wdata_i),
    .carry_flag_i(carry_flag_i), .prog_we_i(prog_we_i),
    .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i),
    .data_rdata_o(data_rdata_o), .pc_o(pc_o), .insn_o(insn_o),
    .option_o(option_o), .add_carry_in_o(add_carry_in_o), .cfg_o(cfg),
    .rc_freq_step_o(rc_freq_step_o), .page_count_o(page_count_o),
    .bank_count_o(bank_count_o), .part_identification_word_o(part_word));

  // free-running 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;

  // -------------------------------------------------------
  // access tasks, all driven on the falling edge
  // -------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp,
           input string m);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task chk_pc(input logic [10:0] ex);
    chk(16'(pc_o), 16'(ex), "pc");
  endtask

  // primary_config_word is set as reset rises and reset is held four cycles so the synchroniser is settled
  task do_reset(input logic [11:0] fw);
    @(negedge sys_clk_i);
    primary_config_word = fw;
    rst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
  endtask

  // one-cycle instruction pulse; pc is settled when this returns
  task op(input logic [4:0] k, input logic [2:0] pv, input logic [7:0] t);
    @(negedge sys_clk_i);
    op_i = {k, pv, t};
    @(negedge sys_clk_i);
    op_i = '0;
  endtask

  task dwr(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    data_addr_i = a;
    data_wdata_i = d;
    data_we_i = 1'b1;
    @(negedge sys_clk_i);
    data_we_i = 1'b0;
  endtask

  task drd(input logic [4:0] a, input logic [7:0] ex);
    @(negedge sys_clk_i);
    data_addr_i = a;
    data_rd_i = 1'b1;
    @(negedge sys_clk_i);
    data_rd_i = 1'b0;
    chk(16'(data_rdata_o), 16'(ex), "data read");
  endtask

  task owr(input logic [7:0] d);
    @(negedge sys_clk_i);
    option_wdata_i = d;
    option_we_i = 1'b1;
    @(negedge sys_clk_i);
    option_we_i = 1'b0;
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    rst_i = 1'b1;
    primary_config_word = 12'h313;
    op_i = '0;
    data_addr_i = 5'h00;
    data_we_i = 1'b0;
    data_rd_i = 1'b0;
    data_wdata_i = 8'h00;
    option_we_i = 1'b0;
    option_wdata_i = 8'h00;
    carry_flag_i = 1'b0;
    prog_we_i = 1'b0;
    prog_addr_i = 11'h000;
    prog_wdata_i = 12'h000;
    bad_count = 0;
    compares = 0;
    // trim 3, full stack, carry fed, brown-out level 1, 4 pages
    do_reset(12'h313);
    chk_pc(11'h7FF);
    chk(16'(option_o), 16'h00FF, "option reset");
    chk(16'(part_word), 16'(PART_ID_DEFAULT), "part id");
    chk(16'(rc_freq_step_o), 16'h0009, "trim step");
    chk(16'({page_count_o, bank_count_o}), 16'h0048, "size");
    chk(16'(cfg.brownout_en), 16'h0001, "brownout on");
    carry_flag_i = 1'b1;
    @(negedge sys_clk_i);
    chk(16'(add_carry_in_o), 16'h0001, "carry in");
    carry_flag_i = 1'b0;
    @(negedge sys_clk_i);
    chk(16'(add_carry_in_o), 16'h0000, "carry in");
    owr(8'h00);
    chk(16'(option_o), 16'h0000, "option writable");
    op(K_STEP, 3'h0, 8'h00);
    chk_pc(11'h000);
    $display("test config_a done");
    // low byte write plus page bits form the counter
    dwr(ADDR_STATUS, 8'h20);
    drd(ADDR_STATUS, 8'h20);
    dwr(ADDR_PC_LOW, 8'hFF);
    chk_pc(11'h1FF);
    drd(ADDR_PC_LOW, 8'hFF);
    op(K_STEP, 3'h0, 8'h00);
    chk_pc(11'h200);
    @(negedge sys_clk_i);
    prog_addr_i = 11'h345;
    prog_wdata_i = 12'hABC;
    prog_we_i = 1'b1;
    @(negedge sys_clk_i);
    prog_we_i = 1'b0;
    op(K_PAGE, 3'h3, 8'h00);
    op(K_JUMP, 3'h0, 8'h45);
    chk_pc(11'h345);
    @(negedge sys_clk_i);
    chk(16'(insn_o), 16'h0ABC, "fetch");
    $display("test paging done");
    // nine calls on an eight-deep stack lose the first return
    for (int i = 1; i <= 9; i++)
    begin
      op(K_CALL, 3'h0, 8'(i * 16));
      chk_pc(11'h300 + 11'(i * 16));
    end
    for (int i = 9; i >= 2; i--)
    begin
      op(K_RET, 3'h0, 8'h00);
      e = 11'h301 + 11'((i - 1) * 16);
      chk_pc(e);
    end
    drd(5'h01, 8'h00);
    $display("test stack8 done");
    // banked locations differ per bank; an indirect write through the pointer reaches global 08h
    dwr(ADDR_FSR, 8'h20);
    dwr(5'h10, 8'h11);
    dwr(ADDR_FSR, 8'h40);
    dwr(5'h10, 8'h22);
    drd(5'h10, 8'h22);
    dwr(ADDR_FSR, 8'h20);
    drd(5'h10, 8'h11);
    dwr(ADDR_FSR, 8'h48);
    dwr(ADDR_INDIRECT, 8'h77);
    drd(5'h08, 8'h77);
    drd(ADDR_FSR, 8'h48);
    $display("test data done");
    // trim 7, short stack, carry off, brown-out off, 1 page 1 bank
    do_reset(12'hBF0);
    chk_pc(11'h1FF);
    chk(16'({page_count_o, bank_count_o}), 16'h0011, "size");
    chk(16'(rc_freq_step_o), 16'h0015, "trim step");
    chk(16'(cfg), 16'h1D60, "cfg");
    carry_flag_i = 1'b1;
    @(negedge sys_clk_i);
    chk(16'(add_carry_in_o), 16'h0000, "carry off");
    owr(8'h00);
    chk(16'(option_o), 16'h00C0, "option forced");
    // a primary_config_word change outside reset must not reach the settings
    primary_config_word = 12'h313;
    repeat (4) @(negedge sys_clk_i);
    chk(16'(cfg), 16'h1D60, "cfg held");
    op(K_STEP, 3'h0, 8'h00);
    chk_pc(11'h000);
    for (int i = 1; i <= 3; i++)
      op(K_CALL, 3'h0, 8'(i * 16));
    chk_pc(11'h030);
    op(K_RET, 3'h0, 8'h00);
    chk_pc(11'h021);
    op(K_RET, 3'h0, 8'h00);
    chk_pc(11'h011);
    // a return right behind a call gives back that call's return address
    @(negedge sys_clk_i);
    op_i = {K_CALL, 3'h0, 8'h40};
    @(negedge sys_clk_i);
    op_i = {K_RET, 3'h0, 8'h00};
    @(negedge sys_clk_i);
    op_i = '0;
    chk_pc(11'h012);
    $display("test config_b done");
    // one page two banks: bank 3 folds onto bank 1
    do_reset(12'h301);
    chk_pc(11'h1FF);
    chk(16'({page_count_o, bank_count_o}), 16'h0012, "size");
    dwr(ADDR_FSR, 8'h20);
    dwr(5'h10, 8'h5A);
    dwr(ADDR_FSR, 8'h60);
    drd(5'h10, 8'h5A);
    // four pages four banks, brown-out third level
    do_reset(12'h322);
    chk_pc(11'h7FF);
    chk(16'({page_count_o, bank_count_o}), 16'h0044, "size");
    chk(16'(cfg.brownout_select), 16'h0002, "brownout level");
    chk(16'(cfg.brownout_en), 16'h0001, "brownout on");
    $display("test sizes done");
    give_verdict();
  end
endmodule
